// ===== verilog/usb_ep_pkg.sv
// package: register map, field layout, codes and carriers of the endpoint block
package usb_ep_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_EP0 = 8'h00;
    localparam logic [7:0] OFS_EP1 = 8'h04;
    localparam logic [7:0] OFS_CTL = 8'h08;

    // values after reset
    localparam logic [7:0] EP0_RESET = 8'h00;
    localparam logic [7:0] EP1_RESET = 8'h00;
    localparam logic CTL_FORCE_RESET = 1'b0;

    // field positions
    localparam int unsigned EP0_FLAG_BIT = 7;
    localparam int unsigned EP0_TXTOG_BIT = 6;
    localparam int unsigned EP0_TXSTAT_LSB = 4;
    localparam int unsigned EP0_RXTOG_BIT = 2;
    localparam int unsigned EP0_RXSTAT_LSB = 0;
    localparam int unsigned EP1_FLAG_BIT = 3;
    localparam int unsigned EP1_RXTOG_BIT = 2;
    localparam int unsigned EP1_RXSTAT_LSB = 0;
    localparam int unsigned CTL_FORCE_BIT = 0;

    // endpoint state field codes
    localparam logic [1:0] STAT_DISABLED = 2'h0;
    localparam logic [1:0] STAT_STALL = 2'h1;
    localparam logic [1:0] STAT_NAK = 2'h2;
    localparam logic [1:0] STAT_VALID = 2'h3;

    typedef enum logic [1:0] {
        ANS_IGNORE, ANS_STALL, ANS_NAK, ANS_HANDLE
    } answer_t;

    typedef enum logic [1:0] {
        PID_OUT = 2'h0, PID_IN = 2'h2, PID_SETUP = 2'h3
    } token_pid_t;

    typedef enum logic [2:0] {
        HS_NONE, HS_ACK, HS_NAK, HS_STALL, HS_DATA
    } hs_code_t;

    typedef enum {ST_IDLE, ST_WAIT_DATA, ST_WAIT_ACK} fsm_t;

    // token seen by the packet engine
    typedef struct packed {
        logic valid;
        logic addr_match;
        logic [3:0] ep;
        token_pid_t pid;
    } token_t;

    // data packet seen by the packet engine
    typedef struct packed {
        logic valid;
        logic ok;
        logic pid1;
    } data_t;

    // answer to the packet engine
    typedef struct packed {
        logic valid;
        hs_code_t code;
        logic data_pid;
    } hs_t;

    typedef struct packed {
        logic flag;
        logic tx_tog;
        logic [1:0] tx_stat;
        logic rsv;
        logic rx_tog;
        logic [1:0] rx_stat;
    } ep0_reg_t;

    typedef struct packed {
        logic [3:0] rsv;
        logic flag;
        logic rx_tog;
        logic [1:0] rx_stat;
    } ep1_reg_t;

endpackage : usb_ep_pkg

// ===== verilog/ep_stat_decode.sv
// decoder of an endpoint state field into the answer it calls for
`timescale 1ns/1ps
module ep_stat_decode (
    input wire logic [1:0] stat,
    output usb_ep_pkg::answer_t answer
);
    always_comb begin
        case (stat)
            usb_ep_pkg::STAT_STALL: answer = usb_ep_pkg::ANS_STALL;
            usb_ep_pkg::STAT_NAK: answer = usb_ep_pkg::ANS_NAK;
            usb_ep_pkg::STAT_VALID: answer = usb_ep_pkg::ANS_HANDLE;
            default: answer = usb_ep_pkg::ANS_IGNORE;
        endcase
    end
endmodule : ep_stat_decode

// ===== verilog/usb_endpoint_state_control.sv
// usb endpoint 0 and endpoint 1 receive state, toggle and apb registers
//
// Function
// - ep0 register resets; usb reset clears fields
// - ep0 correct transfer sets sticky flag
// - toggle bit gives next data pid
// - setup token sets ep0 transmit toggle
// - transmit toggle inverts only after host ack
// - software writes to toggles take effect
// - ep0 transmit state field decoded
// - ep0 receive state field decoded
// - ep0 correct transfer sets both NAK
// - setup stage clears ep0 receive toggle
// - receive toggle inverts on matching correct data
// - setup on enabled ep0 acked, both NAK
// - ep0 stall answer sets both STALL
// - ep0 bit 3 reads zero
// - ep1 register resets; usb reset clears fields
// - ep1 bits 7:4 read zero
// - ep1 correct reception sets sticky flag
// - ep1 receive state field decoded
// - ep1 correct reception sets state NAK
// - correct means error free, expected pid
// - force reset holds; release raises event
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
module usb_endpoint_state_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic usb_bus_reset,
    input wire usb_ep_pkg::token_t token,
    input wire usb_ep_pkg::data_t data_pkt,
    input wire logic host_ack,
    output usb_ep_pkg::hs_t answer,
    output logic force_usb_reset,
    output logic usb_reset_released
);

    typedef struct packed {
        usb_ep_pkg::ep0_reg_t ep0;
        usb_ep_pkg::ep1_reg_t ep1;
        logic ctl_force;
        logic force_prev;
        usb_ep_pkg::fsm_t fsm;
        logic cur_ep1;
        logic cur_setup;
        logic [31:0] prdata;
        usb_ep_pkg::hs_t hs;
        logic rst_done;
    } state_t;

    state_t s;
    state_t next_s;

    usb_ep_pkg::answer_t ans_tx0;
    usb_ep_pkg::answer_t ans_rx0;
    usb_ep_pkg::answer_t ans_rx1;
    usb_ep_pkg::answer_t ans_cur;
    logic usb_rst;
    logic hit;
    logic wr_en;
    logic ep0_wr;
    logic tok_ok;
    logic setup_taken;
    logic ack_taken;
    logic data_good;
    logic pid_match;
    logic ep0_ok;
    logic ep1_ok;
    logic [31:0] rd_word;

    // state field decoders
    ep_stat_decode u_dec_tx0 (
        .stat(s.ep0.tx_stat),
        .answer(ans_tx0)
    );
    ep_stat_decode u_dec_rx0 (
        .stat(s.ep0.rx_stat),
        .answer(ans_rx0)
    );
    ep_stat_decode u_dec_rx1 (
        .stat(s.ep1.rx_stat),
        .answer(ans_rx1)
    );

    assign usb_rst = usb_bus_reset | s.ctl_force;
    assign hit = (paddr == usb_ep_pkg::OFS_EP0)
        || (paddr == usb_ep_pkg::OFS_EP1)
        || (paddr == usb_ep_pkg::OFS_CTL);
    assign wr_en = psel & penable & pwrite & hit;
    assign ep0_wr = wr_en && (paddr == usb_ep_pkg::OFS_EP0);
    assign tok_ok = token.valid && token.addr_match && !usb_rst;
    assign setup_taken = (s.fsm == usb_ep_pkg::ST_IDLE) && tok_ok
        && (token.ep == 4'h0) && (token.pid == usb_ep_pkg::PID_SETUP);
    assign ack_taken = (s.fsm == usb_ep_pkg::ST_WAIT_ACK) && host_ack
        && !usb_rst;
    assign ans_cur = s.cur_ep1 ? ans_rx1 : ans_rx0;
    assign pid_match = s.cur_ep1 ? (data_pkt.pid1 == s.ep1.rx_tog)
        : (data_pkt.pid1 == s.ep0.rx_tog);
    // error free data with expected pid while waiting for data
    assign data_good = (s.fsm == usb_ep_pkg::ST_WAIT_DATA) && !usb_rst
        && data_pkt.valid && data_pkt.ok && pid_match;
    assign ep0_ok = (data_good && !s.cur_ep1
        && (s.cur_setup || ans_cur == usb_ep_pkg::ANS_HANDLE))
        || ack_taken;
    assign ep1_ok = data_good && s.cur_ep1
        && (ans_cur == usb_ep_pkg::ANS_HANDLE);

    // read word, reserved bits held at zero in the state
    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            usb_ep_pkg::OFS_EP0: rd_word[7:0] = s.ep0;
            usb_ep_pkg::OFS_EP1: rd_word[7:0] = s.ep1;
            usb_ep_pkg::OFS_CTL: rd_word[usb_ep_pkg::CTL_FORCE_BIT] =
                s.ctl_force;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.hs = '0;
        next_s.force_prev = s.ctl_force;
        next_s.rst_done = s.force_prev & ~s.ctl_force;
        if (psel && !penable) begin
            next_s.prdata = rd_word;
        end
        // software writes; hardware updates below take priority
        if (wr_en) begin
            case (paddr)
                usb_ep_pkg::OFS_EP0: begin
                    next_s.ep0.flag = s.ep0.flag
                        & pwdata[usb_ep_pkg::EP0_FLAG_BIT];
                    next_s.ep0.tx_tog =
                        pwdata[usb_ep_pkg::EP0_TXTOG_BIT];
                    next_s.ep0.tx_stat =
                        pwdata[usb_ep_pkg::EP0_TXSTAT_LSB +: 2];
                    next_s.ep0.rx_tog =
                        pwdata[usb_ep_pkg::EP0_RXTOG_BIT];
                    next_s.ep0.rx_stat =
                        pwdata[usb_ep_pkg::EP0_RXSTAT_LSB +: 2];
                end
                usb_ep_pkg::OFS_EP1: begin
                    next_s.ep1.flag = s.ep1.flag
                        & pwdata[usb_ep_pkg::EP1_FLAG_BIT];
                    next_s.ep1.rx_tog =
                        pwdata[usb_ep_pkg::EP1_RXTOG_BIT];
                    next_s.ep1.rx_stat =
                        pwdata[usb_ep_pkg::EP1_RXSTAT_LSB +: 2];
                end
                usb_ep_pkg::OFS_CTL: begin
                    next_s.ctl_force = pwdata[usb_ep_pkg::CTL_FORCE_BIT];
                end
                default: begin
                end
            endcase
        end
        // transaction sequencing
        case (s.fsm)
            usb_ep_pkg::ST_IDLE: begin
                if (tok_ok) begin
                    next_s.cur_ep1 = (token.ep == 4'h1);
                    next_s.cur_setup = (token.pid == usb_ep_pkg::PID_SETUP);
                    if (token.ep == 4'h0) begin
                        case (token.pid)
                            usb_ep_pkg::PID_SETUP: begin
                                next_s.ep0.tx_tog = 1'b1;
                                next_s.ep0.rx_tog = 1'b0;
                                if (ans_tx0 != usb_ep_pkg::ANS_IGNORE
                                    || ans_rx0 != usb_ep_pkg::ANS_IGNORE)
                                begin
                                    next_s.fsm = usb_ep_pkg::ST_WAIT_DATA;
                                end
                            end
                            usb_ep_pkg::PID_IN: begin
                                case (ans_tx0)
                                    usb_ep_pkg::ANS_STALL: begin
                                        next_s.hs.valid = 1'b1;
                                        next_s.hs.code = usb_ep_pkg::HS_STALL;
                                        next_s.ep0.tx_stat =
                                            usb_ep_pkg::STAT_STALL;
                                        next_s.ep0.rx_stat =
                                            usb_ep_pkg::STAT_STALL;
                                    end
                                    usb_ep_pkg::ANS_NAK: begin
                                        next_s.hs.valid = 1'b1;
                                        next_s.hs.code = usb_ep_pkg::HS_NAK;
                                    end
                                    usb_ep_pkg::ANS_HANDLE: begin
                                        next_s.hs.valid = 1'b1;
                                        next_s.hs.code = usb_ep_pkg::HS_DATA;
                                        next_s.hs.data_pid =
                                            s.ep0.tx_tog;
                                        next_s.fsm = usb_ep_pkg::ST_WAIT_ACK;
                                    end
                                    default: begin
                                    end
                                endcase
                            end
                            default: begin
                                if (ans_rx0 != usb_ep_pkg::ANS_IGNORE) begin
                                    next_s.fsm =
                                        usb_ep_pkg::ST_WAIT_DATA;
                                end
                            end
                        endcase
                    end else if (token.ep == 4'h1
                        && token.pid == usb_ep_pkg::PID_OUT
                        && ans_rx1 != usb_ep_pkg::ANS_IGNORE) begin
                        next_s.fsm = usb_ep_pkg::ST_WAIT_DATA;
                    end
                end
            end
            usb_ep_pkg::ST_WAIT_DATA: begin
                if (data_pkt.valid) begin
                    next_s.fsm = usb_ep_pkg::ST_IDLE;
                    if (data_pkt.ok && s.cur_setup) begin
                        next_s.hs.valid = 1'b1;
                        next_s.hs.code = usb_ep_pkg::HS_ACK;
                        next_s.ep0.tx_stat = usb_ep_pkg::STAT_NAK;
                        next_s.ep0.rx_stat = usb_ep_pkg::STAT_NAK;
                    end else if (data_pkt.ok) begin
                        case (ans_cur)
                            usb_ep_pkg::ANS_STALL: begin
                                next_s.hs.valid = 1'b1;
                                next_s.hs.code = usb_ep_pkg::HS_STALL;
                                if (!s.cur_ep1) begin
                                    next_s.ep0.tx_stat =
                                        usb_ep_pkg::STAT_STALL;
                                    next_s.ep0.rx_stat =
                                        usb_ep_pkg::STAT_STALL;
                                end
                            end
                            usb_ep_pkg::ANS_NAK: begin
                                next_s.hs.valid = 1'b1;
                                next_s.hs.code = usb_ep_pkg::HS_NAK;
                            end
                            usb_ep_pkg::ANS_HANDLE: begin
                                next_s.hs.valid = 1'b1;
                                next_s.hs.code = usb_ep_pkg::HS_ACK;
                            end
                            default: begin
                            end
                        endcase
                    end
                end else if (token.valid) begin
                    next_s.fsm = usb_ep_pkg::ST_IDLE;
                end
                if (ep0_ok) begin
                    next_s.ep0.rx_tog = ~s.ep0.rx_tog;
                    next_s.ep0.flag = 1'b1;
                    next_s.ep0.tx_stat = usb_ep_pkg::STAT_NAK;
                    next_s.ep0.rx_stat = usb_ep_pkg::STAT_NAK;
                end
                if (ep1_ok) begin
                    next_s.ep1.rx_tog = ~s.ep1.rx_tog;
                    next_s.ep1.flag = 1'b1;
                    next_s.ep1.rx_stat = usb_ep_pkg::STAT_NAK;
                end
            end
            usb_ep_pkg::ST_WAIT_ACK: begin
                if (ack_taken) begin
                    next_s.fsm = usb_ep_pkg::ST_IDLE;
                    next_s.ep0.tx_tog = ~s.ep0.tx_tog;
                    next_s.ep0.flag = 1'b1;
                    next_s.ep0.tx_stat = usb_ep_pkg::STAT_NAK;
                    next_s.ep0.rx_stat = usb_ep_pkg::STAT_NAK;
                end else if (token.valid || data_pkt.valid) begin
                    next_s.fsm = usb_ep_pkg::ST_IDLE;
                end
            end
            default: begin
                next_s.fsm = usb_ep_pkg::ST_IDLE;
            end
        endcase
        // usb reset from bus or software clears the state fields
        if (usb_rst) begin
            next_s.ep0.tx_tog = 1'b0;
            next_s.ep0.tx_stat = usb_ep_pkg::STAT_DISABLED;
            next_s.ep0.rx_tog = 1'b0;
            next_s.ep0.rx_stat = usb_ep_pkg::STAT_DISABLED;
            next_s.ep1.rx_tog = 1'b0;
            next_s.ep1.rx_stat = usb_ep_pkg::STAT_DISABLED;
            next_s.fsm = usb_ep_pkg::ST_IDLE;
            next_s.hs = '0;
        end
        next_s.ep0.rsv = 1'b0;
        next_s.ep1.rsv = 4'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.ep0 <= usb_ep_pkg::EP0_RESET;
            s.ep1 <= usb_ep_pkg::EP1_RESET;
            s.ctl_force <= usb_ep_pkg::CTL_FORCE_RESET;
            s.fsm <= usb_ep_pkg::ST_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~hit;
    assign answer = s.hs;
    assign force_usb_reset = s.ctl_force;
    assign usb_reset_released = s.rst_done;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence in_nak_ep0;
        s.fsm == usb_ep_pkg::ST_IDLE && tok_ok && token.ep == 4'h0
            && token.pid == usb_ep_pkg::PID_IN
            && ans_tx0 == usb_ep_pkg::ANS_NAK;
    endsequence

    sequence out_data_taken;
        s.fsm == usb_ep_pkg::ST_WAIT_DATA && !usb_rst && data_pkt.valid;
    endsequence

    ep0_rsv_zero_a: assert property (s.ep0.rsv == 1'b0)
        else $error("ep0 reserved bit set");
    ep1_rsv_zero_a: assert property (s.ep1.rsv == 4'h0)
        else $error("ep1 reserved bits set");
    usb_rst_clr_a: assert property (usb_rst |=> s.ep0.tx_stat == 2'h0
        && s.ep0.rx_stat == 2'h0 && !s.ep0.tx_tog && !s.ep0.rx_tog
        && s.ep1.rx_stat == 2'h0 && !s.ep1.rx_tog)
        else $error("usb reset left state fields set");
    setup_tog_a: assert property (setup_taken |=>
        s.ep0.tx_tog && !s.ep0.rx_tog)
        else $error("setup did not set tx and clear rx toggle");
    tx_tog_cause_a: assert property ($changed(s.ep0.tx_tog) |->
        $past(ack_taken || ep0_wr || setup_taken || usb_rst))
        else $error("tx toggle changed without cause");
    ep0_ok_nak_a: assert property (ep0_ok |=> s.ep0.flag
        && s.ep0.tx_stat == usb_ep_pkg::STAT_NAK
        && s.ep0.rx_stat == usb_ep_pkg::STAT_NAK)
        else $error("ep0 correct transfer not marked");
    ep1_ok_nak_a: assert property (ep1_ok |=> s.ep1.flag
        && s.ep1.rx_stat == usb_ep_pkg::STAT_NAK)
        else $error("ep1 correct reception not marked");
    flag_hold_a: assert property (s.ep0.flag
        && !(ep0_wr && !pwdata[usb_ep_pkg::EP0_FLAG_BIT]) |=> s.ep0.flag)
        else $error("ep0 flag lost without a zero write");
    in_nak_a: assert property (in_nak_ep0 |=> s.hs.valid
        && s.hs.code == usb_ep_pkg::HS_NAK)
        else $error("nak state did not answer nak");
    stall_both_a: assert property (s.hs.valid
        && s.hs.code == usb_ep_pkg::HS_STALL && !s.cur_ep1 |->
        s.ep0.tx_stat == usb_ep_pkg::STAT_STALL
        && s.ep0.rx_stat == usb_ep_pkg::STAT_STALL)
        else $error("ep0 stall did not stall both directions");
    bad_data_a: assert property (out_data_taken ##0 !data_pkt.ok
        |-> !ep0_ok && !ep1_ok ##1 !s.hs.valid)
        else $error("errored packet treated as correct");
    rst_release_a: assert property ($fell(s.ctl_force) |=>
        usb_reset_released ##1 !usb_reset_released)
        else $error("force reset release not signalled");

endmodule : usb_endpoint_state_control

// ===== verification/usb_host_model.sv
// host side model: sends tokens, data packets and acks
`timescale 1ns/1ps
module usb_host_model (
    input wire logic pclk,
    input wire usb_ep_pkg::hs_t answer,
    output usb_ep_pkg::token_t token,
    output usb_ep_pkg::data_t data_pkt,
    output logic host_ack
);
    initial begin
        token = '0;
        data_pkt = '0;
        host_ack = 1'b0;
    end
    // one transaction; a released field other than the token pid shows its inverse
    task automatic xfer(input logic [3:0] ep,
        input usb_ep_pkg::token_pid_t pid, input logic ok, input logic p1,
        input logic ack, output usb_ep_pkg::hs_t got);
        @(posedge pclk);
        token <= '{1'b1, 1'b1, ep, pid};
        @(posedge pclk);
        token <= '{1'b0, 1'b0, ~ep, pid};
        if (pid != usb_ep_pkg::PID_IN) begin
            @(posedge pclk);
            data_pkt <= '{1'b1, ok, p1};
            @(posedge pclk);
            data_pkt <= '{1'b0, ~ok, ~p1};
        end
        got = '0;
        repeat (4) begin
            #1;
            if (answer.valid === 1'b1) got = answer;
            @(posedge pclk);
        end
        if (pid == usb_ep_pkg::PID_IN && got.code == usb_ep_pkg::HS_DATA
            && ack) begin
            host_ack <= 1'b1;
            @(posedge pclk);
            host_ack <= 1'b0;
        end
    endtask : xfer
endmodule : usb_host_model

// ===== verification/usb_endpoint_state_control_bench.sv
// self-checking bench of the endpoint state and toggle block
`timescale 1ns/1ps
module usb_endpoint_state_control_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic usb_bus_reset = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, host_ack, force_usb_reset, usb_reset_released;
    usb_ep_pkg::token_t token;
    usb_ep_pkg::data_t data_pkt;
    usb_ep_pkg::hs_t answer, got;
    int bad_count = 0;
    int tests_run = 0;
    int seed = 32'hfe0a6fa3;
    int i, t;
    logic [31:0] rd;
    logic [7:0] e0, e1, w;
    logic [1:0] s;
    logic err, ok, hit;
    always #2 pclk = ~pclk;
    usb_endpoint_state_control dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .usb_bus_reset,
        .token, .data_pkt, .host_ack, .answer, .force_usb_reset,
        .usb_reset_released);
    usb_host_model host (.pclk, .answer, .token, .data_pkt, .host_ack);
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    task automatic apb(input logic wr, input logic [7:0] ad,
        input logic [7:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 8; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 8) begin
            bad_count++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [7:0] ad, input logic [7:0] ex,
        input logic [7:0] mk);
        apb(1'b0, ad, 8'h00);
        check($sformatf("reg %h", ad), rd & {24'h0, mk}, {24'h0, ex & mk});
    endtask : rchk
    // {valid, code} expected for a state field
    function automatic logic [3:0] ans_exp(input logic [1:0] st,
        input logic in);
        case (st)
            usb_ep_pkg::STAT_DISABLED: return 4'h0;
            usb_ep_pkg::STAT_STALL: return {1'b1, usb_ep_pkg::HS_STALL};
            usb_ep_pkg::STAT_NAK: return {1'b1, usb_ep_pkg::HS_NAK};
            default: return {1'b1, in ? usb_ep_pkg::HS_DATA
                : usb_ep_pkg::HS_ACK};
        endcase
    endfunction : ans_exp
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rchk(usb_ep_pkg::OFS_EP0, 8'h00, 8'hff);
        rchk(usb_ep_pkg::OFS_EP1, 8'h00, 8'hff);
        rchk(usb_ep_pkg::OFS_CTL, 8'h00, 8'hff);
        apb(1'b1, 8'h0c, 8'hff);
        check("unmapped err", err, 1'b1);
        $display("end reset and map");
        e1 = 8'h00;
        for (int k = 0; k < 24; k++) begin
            t = k / 8;
            s = k[1:0];
            w = $random(seed);
            ok = (k % 8) != 7 || t == 0;
            if (t == 2) begin
                e1 = {5'h0, w[2], s};
                apb(1'b1, usb_ep_pkg::OFS_EP1, {w[7:4], 1'b0, w[2], s});
                host.xfer(4'h1, usb_ep_pkg::PID_OUT, ok, e1[2] ^ k[2], 1'b0,
                    got);
            end else begin
                e0 = {1'b0, w[6], t ? ~s : s, 1'b0, w[2], t ? s : ~s};
                apb(1'b1, usb_ep_pkg::OFS_EP0, e0 | 8'h08);
                if (t == 0) host.xfer(4'h0, usb_ep_pkg::PID_IN, 1'b1, 1'b0,
                    w[3], got);
                else host.xfer(4'h0, usb_ep_pkg::PID_OUT, ok, e0[2] ^ k[2],
                    1'b0, got);
            end
            check("answer", {got.valid, got.code},
                ok ? ans_exp(s, t == 0) : 4'h0);
            if (t == 0 && s == 2'h3)
                check("data pid", got.data_pid, e0[6]);
            hit = s == 2'h3 && ok && (t == 0 ? w[3] : !k[2]);
            if (hit && t == 2) e1 = {4'h0, 1'b1, ~e1[2], 2'h2};
            else if (hit) e0 = {1'b1, e0[6] ^ (t == 0), 2'h2, 1'b0,
                e0[2] ^ (t == 1), 2'h2};
            if (s == 2'h1 && t < 2) e0 = {e0[7:6], 2'h1, e0[3:2], 2'h1};
            rchk(usb_ep_pkg::OFS_EP0, e0, 8'hff);
            rchk(usb_ep_pkg::OFS_EP1, e1,
                (t == 2 && s == 2'h1) ? 8'hfc : 8'hff);
        end
        $display("end state decode");
        apb(1'b1, usb_ep_pkg::OFS_EP0, 8'h21);
        host.xfer(4'h0, usb_ep_pkg::PID_SETUP, 1'b1, 1'b0, 1'b0, got);
        check("setup ack", got.code, usb_ep_pkg::HS_ACK);
        rchk(usb_ep_pkg::OFS_EP0, 8'he6, 8'hff);
        apb(1'b1, usb_ep_pkg::OFS_EP0, 8'he2);
        rchk(usb_ep_pkg::OFS_EP0, 8'he2, 8'hff);
        apb(1'b1, usb_ep_pkg::OFS_EP1, 8'h03);
        host.xfer(4'h1, usb_ep_pkg::PID_OUT, 1'b1, 1'b1, 1'b0, got);
        check("mismatch ack", got.code, usb_ep_pkg::HS_ACK);
        rchk(usb_ep_pkg::OFS_EP1, 8'h03, 8'hff);
        $display("end setup");
        apb(1'b1, usb_ep_pkg::OFS_CTL, 8'h01);
        @(negedge pclk);
        check("force level", force_usb_reset, 1'b1);
        rchk(usb_ep_pkg::OFS_EP0, 8'h80, 8'hff);
        rchk(usb_ep_pkg::OFS_EP1, e1 & 8'h08, 8'hff);
        apb(1'b1, usb_ep_pkg::OFS_CTL, 8'h00);
        for (i = 0; i < 6 && usb_reset_released !== 1'b1; i++)
            @(negedge pclk);
        check("release pulse", i, 32'd2);
        apb(1'b1, usb_ep_pkg::OFS_EP0, 8'h77);
        rchk(usb_ep_pkg::OFS_EP0, 8'h77, 8'hff);
        @(posedge pclk);
        usb_bus_reset <= 1'b1;
        repeat (2) @(posedge pclk);
        usb_bus_reset <= 1'b0;
        rchk(usb_ep_pkg::OFS_EP0, 8'h00, 8'hff);
        $display("end usb reset");
        final_report();
    end
endmodule : usb_endpoint_state_control_bench
